// ==== core/afe_cfg_params.svh ====
`ifndef AFE_CFG_PARAMS_SVH
`define AFE_CFG_PARAMS_SVH

// register offsets
`define ADDR_OUTPUT_FORMAT_CONTROL 8'h14
`define ADDR_OUTPUT_DRIVE_ADJUST   8'h15
`define ADDR_REFERENCE_SELECT      8'h18
`define ADDR_USER_PATTERN_ONE_LOW  8'h19
`define ADDR_USER_PATTERN_ONE_HIGH 8'h1a
`define ADDR_USER_PATTERN_TWO_LOW  8'h1b
`define ADDR_USER_PATTERN_TWO_HIGH 8'h1c
`define ADDR_FILTER_TUNE_CONTROL   8'h2b

// reset values
`define RST_OUTPUT_FORMAT_CONTROL 8'h00
`define RST_OUTPUT_DRIVE_ADJUST   8'h0f
`define RST_REFERENCE_SELECT      8'h03
`define RST_USER_PATTERN          8'h00
`define RST_FILTER_TUNE_CONTROL   8'h00

// field positions
`define BIT_FORMAT_TWOS     0
`define BIT_OUTPUT_INVERT   2
`define BIT_OUTPUT_DISABLE  7
`define MSB_SLEW            3
`define LSB_SLEW            2
`define MSB_DRIVE           1
`define LSB_DRIVE           0
`define BIT_REF_EXTERNAL    6
`define MSB_REF_TRIM        1
`define LSB_REF_TRIM        0
`define BIT_TUNE_START      6

// writable bit masks; unlisted bits read as zero
`define MASK_OUTPUT_FORMAT_CONTROL 8'h05
`define MASK_OUTPUT_DRIVE_ADJUST   8'h8f
`define MASK_REFERENCE_SELECT      8'h43

// drive code with the strongest setting, shared by two codes
`define DRIVE_STRONGEST 2'h2

// tuning duration in core_clk cycles (arbitrary; analog tuning modelled as a wait)
`define TUNE_TIME_NS     1000
`define CLK_PERIOD_NS    25
`define TUNE_CYCLES      (`TUNE_TIME_NS / `CLK_PERIOD_NS)
`define TUNE_CNT_W       6

`endif

// ==== core/afe_cfg_pkg.sv ====
package afe_cfg_pkg;

   typedef struct packed
   {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed
   {
      logic       twos_complement;
      logic       invert;
      logic       outputs_enabled;
      logic [1:0] slew_code;
      logic [1:0] drive_level;
      logic       ref_external;
      logic [1:0] ref_trim;
   } afe_settings_t;

   typedef enum logic [1:0]
   {
      TUNE_IDLE = 2'b00,
      TUNE_RUN  = 2'b01,
      TUNE_DONE = 2'b11
   } tune_state_t;

endpackage : afe_cfg_pkg

// ==== core/user_pattern_mux.sv ====
`include "afe_cfg_params.svh"

// alternates word one and word two of the user pattern while enabled
module user_pattern_mux
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        srst,
   // control
   input  wire logic        pattern_en,
   input  wire logic [15:0] pattern_one,
   input  wire logic [15:0] pattern_two,
   // output
   output logic [15:0]      pattern_word_reg,
   output logic             word_two_reg
);

   always_ff @(posedge core_clk)
   begin
      if (srst || !pattern_en)
      begin
         word_two_reg <= 1'b0;
      end
      else
      begin
         word_two_reg <= ~word_two_reg;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         pattern_word_reg <= 16'h0000;
      end
      else if (pattern_en)
      begin
         pattern_word_reg <= word_two_reg ? pattern_two : pattern_one; // RULE_10
      end
      else
      begin
         pattern_word_reg <= 16'h0000;
      end
   end

endmodule : user_pattern_mux

// ==== core/afe_output_and_reference_config.sv ====
//
// Contract
// RULE_01 - format bit clear gives offset binary (reset), set gives twos complement, for all channels.
// RULE_02 - bit 2 of the output format register set inverts the output data bits per channel.
// RULE_03 - bit 7 of the drive adjust register enables the 12 data outputs at 0; reset is 0x0f.
// RULE_04 - bit 6 of the reference register picks internal reference at 0, external at 1.
// RULE_05 - low two bits of the reference register trim the internal reference; reset code 11.
// RULE_06 - user pattern one is held as low byte at 0x19 and high byte at 0x1a, reset zero.
// RULE_07 - user pattern two is held as low byte at 0x1b and high byte at 0x1c, reset zero.
// RULE_08 - writing 1 to bit 6 of the filter register starts tuning and the bit clears itself.
// RULE_09 - a two-bit drive field picks one of three strengths, codes 10 and 11 alike; reset 11.
// RULE_10 - in user input test mode word one and word two alternate on the output.
// RULE_11 - the tuning start bit reads 0 once tuning has finished.
//
`include "afe_cfg_params.svh"

module afe_output_and_reference_config
(
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      srst,
   // register access from the serial control port
   input  wire afe_cfg_pkg::reg_req_t     reg_req,
   output logic [7:0]                     rdata_reg,
   output logic                           rvalid_reg,
   // test pattern selection from the test register bank
   input  wire logic                      user_pattern_mode,
   // settings to the analog and output stages
   output afe_cfg_pkg::afe_settings_t     settings,
   output logic                           tune_start_pulse,
   output logic                           tune_busy,
   // user pattern output
   output logic [15:0]                    pattern_word,
   output logic                           pattern_word_two
);
   import afe_cfg_pkg::*;

   logic [7:0]  output_format_control_reg;
   logic [7:0]  output_drive_adjust_reg;
   logic [7:0]  reference_select_reg;
   logic [7:0]  user_pattern_one_low_reg;
   logic [7:0]  user_pattern_one_high_reg;
   logic [7:0]  user_pattern_two_low_reg;
   logic [7:0]  user_pattern_two_high_reg;
   logic        tune_start_reg;
   tune_state_t tune_state_reg;
   tune_state_t tune_state_next;
   logic [`TUNE_CNT_W-1:0] tune_cnt_reg;
   logic        tune_start_write;
   logic [7:0]  rdata_next;

   localparam logic [`TUNE_CNT_W-1:0] TUNE_LAST = `TUNE_CNT_W'(`TUNE_CYCLES - 1);

   function automatic logic wr_hit(input reg_req_t req, input logic [7:0] addr);
      wr_hit = req.wr_en && (req.addr == addr);
   endfunction : wr_hit

   // output format and per-channel invert
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         output_format_control_reg <= `RST_OUTPUT_FORMAT_CONTROL; // RULE_01
      end
      else if (wr_hit(reg_req, `ADDR_OUTPUT_FORMAT_CONTROL))
      begin
         output_format_control_reg <= reg_req.wdata & `MASK_OUTPUT_FORMAT_CONTROL;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         output_drive_adjust_reg <= `RST_OUTPUT_DRIVE_ADJUST; // RULE_03
      end
      else if (wr_hit(reg_req, `ADDR_OUTPUT_DRIVE_ADJUST))
      begin
         output_drive_adjust_reg <= reg_req.wdata & `MASK_OUTPUT_DRIVE_ADJUST;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         reference_select_reg <= `RST_REFERENCE_SELECT; // RULE_05
      end
      else if (wr_hit(reg_req, `ADDR_REFERENCE_SELECT))
      begin
         reference_select_reg <= reg_req.wdata & `MASK_REFERENCE_SELECT;
      end
   end

   // user patterns
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         user_pattern_one_low_reg  <= `RST_USER_PATTERN; // RULE_06
         user_pattern_one_high_reg <= `RST_USER_PATTERN; // RULE_06
      end
      else
      begin
         if (wr_hit(reg_req, `ADDR_USER_PATTERN_ONE_LOW))
         begin
            user_pattern_one_low_reg <= reg_req.wdata;
         end
         if (wr_hit(reg_req, `ADDR_USER_PATTERN_ONE_HIGH))
         begin
            user_pattern_one_high_reg <= reg_req.wdata;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         user_pattern_two_low_reg  <= `RST_USER_PATTERN; // RULE_07
         user_pattern_two_high_reg <= `RST_USER_PATTERN; // RULE_07
      end
      else
      begin
         if (wr_hit(reg_req, `ADDR_USER_PATTERN_TWO_LOW))
         begin
            user_pattern_two_low_reg <= reg_req.wdata;
         end
         if (wr_hit(reg_req, `ADDR_USER_PATTERN_TWO_HIGH))
         begin
            user_pattern_two_high_reg <= reg_req.wdata;
         end
      end
   end

   // filter tuning: start bit stays set while tuning runs, so polling sees completion
   assign tune_start_write = wr_hit(reg_req, `ADDR_FILTER_TUNE_CONTROL)
                             && reg_req.wdata[`BIT_TUNE_START];

   always_comb
   begin
      tune_state_next = tune_state_reg;
      unique case (tune_state_reg)
         TUNE_IDLE:
         begin
            if (tune_start_write)
            begin
               tune_state_next = TUNE_RUN; // RULE_08
            end
         end
         TUNE_RUN:
         begin
            if (tune_cnt_reg == TUNE_LAST)
            begin
               tune_state_next = TUNE_DONE;
            end
         end
         TUNE_DONE:
         begin
            tune_state_next = TUNE_IDLE;
         end
         default:
         begin
            tune_state_next = TUNE_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         tune_state_reg <= TUNE_IDLE;
      end
      else
      begin
         tune_state_reg <= tune_state_next;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || tune_state_reg != TUNE_RUN)
      begin
         tune_cnt_reg <= '0;
      end
      else
      begin
         tune_cnt_reg <= tune_cnt_reg + `TUNE_CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         tune_start_reg <= 1'(`RST_FILTER_TUNE_CONTROL >> `BIT_TUNE_START);
      end
      else if (tune_start_write && tune_state_reg == TUNE_IDLE)
      begin
         tune_start_reg <= 1'b1;
      end
      else if (tune_state_reg == TUNE_DONE)
      begin
         tune_start_reg <= 1'b0; // RULE_08 RULE_11
      end
   end

   assign tune_start_pulse = tune_start_write && (tune_state_reg == TUNE_IDLE);
   assign tune_busy        = tune_start_reg;

   // read path: one cycle after rd_en
   always_comb
   begin
      rdata_next = 8'h00;
      unique case (reg_req.addr)
         `ADDR_OUTPUT_FORMAT_CONTROL: rdata_next = output_format_control_reg;
         `ADDR_OUTPUT_DRIVE_ADJUST:   rdata_next = output_drive_adjust_reg;
         `ADDR_REFERENCE_SELECT:      rdata_next = reference_select_reg;
         `ADDR_USER_PATTERN_ONE_LOW:  rdata_next = user_pattern_one_low_reg;
         `ADDR_USER_PATTERN_ONE_HIGH: rdata_next = user_pattern_one_high_reg;
         `ADDR_USER_PATTERN_TWO_LOW:  rdata_next = user_pattern_two_low_reg;
         `ADDR_USER_PATTERN_TWO_HIGH: rdata_next = user_pattern_two_high_reg;
         `ADDR_FILTER_TUNE_CONTROL:   rdata_next = {1'b0, tune_start_reg, 6'h00}; // RULE_11
         default:                     rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rvalid_reg <= reg_req.rd_en;
         if (reg_req.rd_en)
         begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // settings decode
   always_comb
   begin
      settings.twos_complement = output_format_control_reg[`BIT_FORMAT_TWOS];       // RULE_01
      settings.invert          = output_format_control_reg[`BIT_OUTPUT_INVERT];     // RULE_02
      settings.outputs_enabled = ~output_drive_adjust_reg[`BIT_OUTPUT_DISABLE];     // RULE_03
      settings.slew_code       = output_drive_adjust_reg[`MSB_SLEW:`LSB_SLEW];
      // codes 10 and 11 collapse onto one strongest level
      settings.drive_level     = output_drive_adjust_reg[`MSB_DRIVE]
                                 ? `DRIVE_STRONGEST
                                 : output_drive_adjust_reg[`MSB_DRIVE:`LSB_DRIVE];  // RULE_09
      settings.ref_external    = reference_select_reg[`BIT_REF_EXTERNAL];           // RULE_04
      settings.ref_trim        = reference_select_reg[`MSB_REF_TRIM:`LSB_REF_TRIM]; // RULE_05
   end

   user_pattern_mux u_pattern
   (
      .core_clk         (core_clk),
      .srst             (srst),
      .pattern_en       (user_pattern_mode),
      .pattern_one      ({user_pattern_one_high_reg, user_pattern_one_low_reg}),
      .pattern_two      ({user_pattern_two_high_reg, user_pattern_two_low_reg}),
      .pattern_word_reg (pattern_word),
      .word_two_reg     (pattern_word_two)
   );

endmodule : afe_output_and_reference_config

// ==== tb/afe_cfg_chk.sv ====
`include "afe_cfg_params.svh"
module afe_cfg_chk
(
   // clock and reset
   input wire logic                  core_clk,
   input wire logic                  srst,
   // register port
   input wire afe_cfg_pkg::reg_req_t reg_req,
   input wire logic [7:0]            rdata_reg,
   input wire logic                  rvalid_reg,
   // outputs
   input wire logic                  user_pattern_mode,
   input wire afe_cfg_pkg::afe_settings_t settings,
   input wire logic                  tune_start_pulse,
   input wire logic                  tune_busy,
   input wire logic [15:0]           pattern_word,
   input wire logic                  pattern_word_two
);
   timeunit 1ns;
   timeprecision 1ps;
   import afe_cfg_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   logic wr_fmt, wr_adj, wr_ref, rd_hole;
   logic [7:0] wd;
   assign wd = reg_req.wdata;
   assign wr_fmt = reg_req.wr_en && reg_req.addr == 8'h14;
   assign wr_adj = reg_req.wr_en && reg_req.addr == 8'h15;
   assign wr_ref = reg_req.wr_en && reg_req.addr == 8'h18;
   assign rd_hole = reg_req.rd_en && !(reg_req.addr inside {8'h14, 8'h15, [8'h18:8'h1c], 8'h2b});
   read_valid_a: assert property (reg_req.rd_en |=> rvalid_reg) else $error("no read valid");
   hole_zero_a: assert property (rd_hole |=> rdata_reg == 8'h00) else $error("hole read");
   format_bits_a: assert property (wr_fmt |=> settings.twos_complement == $past(wd[0])
      && settings.invert == $past(wd[2])) else $error("format bits");
   out_enable_a: assert property (wr_adj |=> settings.outputs_enabled != $past(wd[7]))
      else $error("output enable");
   drive_code_a: assert property (wr_adj |=> settings.drive_level ==
      ($past(wd[1]) ? 2'h2 : $past(wd[1:0]))) else $error("drive code");
   ref_select_a: assert property (wr_ref |=> settings.ref_external == $past(wd[6])
      && settings.ref_trim == $past(wd[1:0])) else $error("reference");
   tune_accept_a: assert property (tune_start_pulse ==
      (reg_req.wr_en && reg_req.addr == 8'h2b && wd[6] && !tune_busy)) else $error("start");
   tune_clear_a: assert property (tune_start_pulse |-> ##41 tune_busy ##1 !tune_busy)
      else $error("tune length");
   pattern_alt_a: assert property (user_pattern_mode [*3] |->
      pattern_word_two != $past(pattern_word_two)) else $error("pattern order");
   cover property (tune_start_pulse);
   cover property (rvalid_reg && rdata_reg != 8'h00);
   cover property (user_pattern_mode && pattern_word_two);
endmodule : afe_cfg_chk

bind afe_output_and_reference_config afe_cfg_chk i_afe_cfg_chk (.core_clk(core_clk),
   .srst(srst), .reg_req(reg_req), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg),
   .user_pattern_mode(user_pattern_mode), .settings(settings),
   .tune_start_pulse(tune_start_pulse), .tune_busy(tune_busy),
   .pattern_word(pattern_word), .pattern_word_two(pattern_word_two));

// ==== tb/host_ctrl_model.sv ====
module host_ctrl_model
(
   // clock
   input  wire logic             core_clk,
   // register port
   output afe_cfg_pkg::reg_req_t reg_req,
   input  wire logic [7:0]       rdata_reg,
   input  wire logic             rvalid_reg,
   // status
   output logic                  stalled
);
   timeunit 1ns;
   timeprecision 1ps;
   import afe_cfg_pkg::*;
   initial
   begin
      reg_req = '0;
      stalled = 1'b0;
   end
   // idle lines show the inverse so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_req <= '{1'b1, 1'b0, a, d};
      @(negedge core_clk);
      reg_req <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge core_clk);
      reg_req <= '{1'b0, 1'b1, a, ~reg_req.wdata};
      @(negedge core_clk);
      reg_req <= '{1'b0, 1'b0, ~a, reg_req.wdata};
      n = 0;
      while (rvalid_reg !== 1'b1 && n < 4)
      begin
         @(negedge core_clk);
         n++;
      end
      d = rdata_reg;
      if (rvalid_reg !== 1'b1)
         stalled = 1'b1;
   endtask : rd
endmodule : host_ctrl_model

// ==== tb/afe_output_and_reference_config_tb_top.sv ====
module afe_output_and_reference_config_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import afe_cfg_pkg::*;
   logic          core_clk = 1'b0;
   logic          srst = 1'b1;
   logic          user_pattern_mode = 1'b0;
   reg_req_t      reg_req;
   afe_settings_t settings;
   logic [7:0]    rdata_reg, rd_val;
   logic [15:0]   pattern_word;
   logic          rvalid_reg, tune_start_pulse, tune_busy, pattern_word_two, stalled;
   int            fail_count = 0;
   int            samples_checked = 0;
   logic [7:0]    adr [8] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h2b};
   logic [7:0]    rst [8] = '{8'h00, 8'h0f, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]    msk [8] = '{8'h05, 8'h8f, 8'h43, 8'hff, 8'hff, 8'hff, 8'hff, 8'h40};

   always #12.5 core_clk = ~core_clk;

   host_ctrl_model i_host_ctrl_model (.core_clk(core_clk), .reg_req(reg_req),
      .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg), .stalled(stalled));
   afe_output_and_reference_config i_afe_output_and_reference_config (.core_clk(core_clk),
      .srst(srst), .reg_req(reg_req), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg),
      .user_pattern_mode(user_pattern_mode), .settings(settings),
      .tune_start_pulse(tune_start_pulse), .tune_busy(tune_busy),
      .pattern_word(pattern_word), .pattern_word_two(pattern_word_two));

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      i_host_ctrl_model.rd(a, rd_val);
      chk("read data", 16'(rd_val), 16'(exp));
   endtask : rchk

   task automatic final_report;
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   always @(posedge stalled)
   begin
      fail_count++;
      final_report();
   end

   initial
   begin
      int   n;
      logic first;
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      chk("settings", 16'(settings), 16'h00f3);
      for (n = 0; n < 8; n++)
         rchk(adr[n], rst[n]);
      // the tuning register is left out here: a start would run on
      for (n = 0; n < 7; n++)
      begin
         i_host_ctrl_model.wr(adr[n], 8'hff);
         rchk(adr[n], msk[n]);
      end
      chk("settings", 16'(settings), 16'h0377);
      i_host_ctrl_model.wr(8'h16, 8'hff);
      rchk(8'h16, 8'h00);
      for (n = 0; n < 4; n++)
      begin
         i_host_ctrl_model.wr(8'h15, 8'(n));
         i_host_ctrl_model.wr(8'h18, 8'(n));
         chk("drive", 16'(settings.drive_level), n[1] ? 16'h2 : 16'(n));
         chk("trim", 16'({settings.ref_external, settings.ref_trim}), 16'(n));
      end
      i_host_ctrl_model.wr(8'h19, 8'ha5);
      i_host_ctrl_model.wr(8'h1a, 8'h3c);
      i_host_ctrl_model.wr(8'h1b, 8'h5a);
      i_host_ctrl_model.wr(8'h1c, 8'hc3);
      user_pattern_mode = 1'b1;
      repeat (3) @(negedge core_clk);
      first = pattern_word_two;
      for (n = 0; n < 4; n++)
      begin
         chk("word two", 16'(pattern_word_two), 16'(first ^ n[0]));
         // the word-two flag leads the word by one cycle: high while word one is shown
         chk("pattern", pattern_word, pattern_word_two ? 16'h3ca5 : 16'hc35a);
         @(negedge core_clk);
      end
      user_pattern_mode = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("pattern off", pattern_word, 16'h0000);
      i_host_ctrl_model.wr(8'h2b, 8'hff);
      chk("busy", 16'(tune_busy), 16'h1);
      rchk(8'h2b, 8'h40);
      i_host_ctrl_model.wr(8'h2b, 8'h40);
      n = 0;
      while (tune_busy !== 1'b0 && n < 60)
      begin
         @(negedge core_clk);
         n++;
      end
      if (tune_busy !== 1'b0)
      begin
         fail_count++;
         final_report();
      end
      rchk(8'h2b, 8'h00);
      i_host_ctrl_model.wr(8'h14, 8'h05);
      srst = 1'b1;
      @(negedge core_clk);
      srst = 1'b0;
      rchk(8'h14, 8'h00);
      chk("settings", 16'(settings), 16'h00f3);
      final_report();
   end
endmodule : afe_output_and_reference_config_tb_top
